// ===== rtl/porm_top.sv
// Port pin functions and remappable peripheral output multiplexer.
`timescale 1ns/1ps
module porm_top
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RESET,
  // Register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Port A pins
  input  wire logic [7:0] PA_IN,
  output logic      [7:0] PA_OUT,
  output logic      [7:0] PA_OE,
  // Port C pins
  input  wire logic [7:0] PC_IN,
  output logic      [7:0] PC_OUT,
  output logic      [7:0] PC_OE,
  // Peripheral outputs
  input  wire logic       COMPARATOR_ONE_OUT,
  input  wire logic       COMPARATOR_TWO_OUT,
  input  wire logic       SERIAL2_TX_OR_CLOCK,
  input  wire logic       SERIAL2_SYNC_DATA,
  input  wire logic       SPI_PORT2_DATA_OUT,
  input  wire logic       SPI_PORT2_CLOCK_OUT,
  input  wire logic       SERIAL_DMA_SLAVE_SELECT,
  input  wire logic       LOW_POWER_WAKE_EVENT,
  input  wire logic [3:0] PWM_UNIT1_CHANNELS,
  input  wire logic [3:0] PWM_UNIT2_CHANNELS,
  // Fixed-pin peripherals
  input  wire logic [1:0] SERIAL1_MODE,
  input  wire logic       SERIAL1_ASYNC_TX,
  input  wire logic       SERIAL1_SYNC_CLOCK,
  input  wire logic       SERIAL1_SYNC_DATA,
  input  wire logic       SPI_PORT1_ENABLE,
  input  wire logic       SPI_PORT1_DATA_OUT,
  input  wire logic       CYCLE_CLOCK_MODE,
  // Pin levels back to peripherals
  output logic      [7:0] PA_DIGITAL_IN,
  output logic      [7:0] PC_DIGITAL_IN
);

  // ********************************************************************
  // Register state
  // ********************************************************************
  logic [7:0] lat_a;
  logic [7:0] dir_a;
  logic [7:0] ana_cfg;
  logic [7:0] lat_c;
  logic [7:0] dir_c;
  logic [7:0] next_lat_a;
  logic [7:0] next_dir_a;
  logic [7:0] next_ana_cfg;
  logic [7:0] next_lat_c;
  logic [7:0] next_dir_c;
  logic [7:0] rd_mux;
  logic [7:0] next_rd_mux;
  logic       rd_sel_q;
  logic       sel_wr;
  logic [1:0] sel_idx;
  logic [porm_pkg::SEL_W-1:0] sel_rd;
  logic [porm_pkg::NUM_REMAP*porm_pkg::SEL_W-1:0] sel_flat;
  logic [porm_pkg::NUM_REMAP-1:0] remap_val;
  logic [porm_pkg::NUM_REMAP-1:0] remap_on;
  logic [porm_pkg::NUM_REMAP-1:0] remap_dir;
  logic [1:0] cyc_cnt;
  logic [1:0] next_cyc_cnt;
  logic       cyc_clk;
  logic       next_cyc_clk;
  logic       an4_digital_off;
  porm_pkg::porm_s1mode_e s1_mode;

  // Maps a remap select code to the peripheral output it names.
  function automatic logic route_fn(input logic [porm_pkg::SEL_W-1:0] code,
                                    input logic [15:0] srcs);
    logic r;
    r = 1'b0;
    case (code)
      porm_pkg::FN_CMP1:   r = srcs[0];
      porm_pkg::FN_CMP2:   r = srcs[1];
      porm_pkg::FN_S2TXCK: r = srcs[2];
      porm_pkg::FN_S2DT:   r = srcs[3];
      porm_pkg::FN_SPI2DO: r = srcs[4];
      porm_pkg::FN_SPI2CK: r = srcs[5];
      porm_pkg::FN_SERIAL_DMA_SLAVE_SELECT:  r = srcs[6];
      porm_pkg::FN_ULPW:   r = srcs[7];
      default:
      begin
        if (code >= porm_pkg::FN_P1A && code <= porm_pkg::FN_P1D)
        begin
          r = srcs[8 + 32'(code - porm_pkg::FN_P1A)];
        end
        else if (code >= porm_pkg::FN_P2A && code <= porm_pkg::FN_P2D)
        begin
          r = srcs[12 + 32'(code - porm_pkg::FN_P2A)];
        end
      end
    endcase
    return r;
  endfunction

  // Tells whether a code names an implemented output; null and gaps do not.
  function automatic logic code_valid(input logic [porm_pkg::SEL_W-1:0] code);
    logic v;
    v = (code == porm_pkg::FN_CMP1) || (code == porm_pkg::FN_CMP2) ||
        (code == porm_pkg::FN_S2TXCK) || (code == porm_pkg::FN_S2DT) ||
        (code == porm_pkg::FN_SPI2DO) || (code == porm_pkg::FN_SPI2CK) ||
        (code == porm_pkg::FN_SERIAL_DMA_SLAVE_SELECT) ||
        (code >= porm_pkg::FN_ULPW && code <= porm_pkg::FN_P2D);
    return v;
  endfunction

  // ********************************************************************
  // Register writes
  // ********************************************************************

  // Software writes update latches, directions and analog selection.
  always_comb
  begin
    next_lat_a   = lat_a;
    next_dir_a   = dir_a;
    next_ana_cfg = ana_cfg;
    next_lat_c   = lat_c;
    next_dir_c   = dir_c;
    if (WR)
    begin
      unique case (ADDR)
        porm_pkg::REG_PORT_A_PINS,
        porm_pkg::REG_PORT_A_LATCH:     next_lat_a   = WDATA & porm_pkg::PORT_A_IMPL;
        porm_pkg::REG_PORT_A_DIRECTION: next_dir_a   = WDATA & porm_pkg::PORT_A_IMPL;
        porm_pkg::REG_ANALOG_CONFIG_0:  next_ana_cfg = WDATA;
        porm_pkg::REG_PORT_C_PINS,
        porm_pkg::REG_PORT_C_LATCH:     next_lat_c   = WDATA;
        porm_pkg::REG_PORT_C_DIRECTION: next_dir_c   = WDATA;
        default:                        next_lat_a   = lat_a;
      endcase
    end
  end

  // Directions reset to input; analog bits reset to 0 which selects analog.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      lat_a   <= porm_pkg::RST_LATCH;
      dir_a   <= porm_pkg::RST_DIRECTION & porm_pkg::PORT_A_IMPL;
      ana_cfg <= porm_pkg::RST_ANALOG;
      lat_c   <= porm_pkg::RST_LATCH;
      dir_c   <= porm_pkg::RST_DIRECTION;
    end
    else
    begin
      lat_a   <= next_lat_a;
      dir_a   <= next_dir_a;
      ana_cfg <= next_ana_cfg;
      lat_c   <= next_lat_c;
      dir_c   <= next_dir_c;
    end
  end

  // Select register writes are routed to the select store.
  assign sel_wr  = WR && (ADDR >= porm_pkg::REG_REMAP_SEL_RP2) &&
                   (ADDR <= porm_pkg::REG_REMAP_SEL_RP18);
  assign sel_idx = 2'(ADDR - porm_pkg::REG_REMAP_SEL_RP2);

  porm_sel_reg u_sel
  (
    .clk      (CLK),
    .reset    (RESET),
    .wr_en    (sel_wr),
    .wr_idx   (sel_idx),
    .wr_data  (WDATA[porm_pkg::SEL_W-1:0]),
    .rd_idx   (sel_idx),
    .rd_data  (sel_rd),
    .sel_flat (sel_flat)
  );

  // ********************************************************************
  // Register reads
  // ********************************************************************

  // Read data is registered; select reads come from the memory register.
  always_comb
  begin
    next_rd_mux = 8'h00;
    if (RD)
    begin
      unique case (ADDR)
        porm_pkg::REG_PORT_A_PINS:      next_rd_mux = PA_DIGITAL_IN;
        porm_pkg::REG_PORT_A_LATCH:     next_rd_mux = lat_a;
        porm_pkg::REG_PORT_A_DIRECTION: next_rd_mux = dir_a;
        porm_pkg::REG_ANALOG_CONFIG_0:  next_rd_mux = ana_cfg;
        porm_pkg::REG_PORT_C_PINS:      next_rd_mux = PC_DIGITAL_IN;
        porm_pkg::REG_PORT_C_LATCH:     next_rd_mux = lat_c;
        porm_pkg::REG_PORT_C_DIRECTION: next_rd_mux = dir_c;
        default:                        next_rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      rd_mux   <= 8'h00;
      rd_sel_q <= 1'b0;
    end
    else
    begin
      rd_mux   <= next_rd_mux;
      rd_sel_q <= RD && (ADDR >= porm_pkg::REG_REMAP_SEL_RP2) &&
                  (ADDR <= porm_pkg::REG_REMAP_SEL_RP18);
    end
  end

  // Read data stands only in the cycle after the read strobe.
  assign RDATA = rd_sel_q ? {3'h0, sel_rd} : rd_mux;

  // ********************************************************************
  // Cycle clock divider
  // ********************************************************************

  // Quarter-rate square wave, with one clock standing for the oscillator.
  always_comb
  begin
    next_cyc_cnt = cyc_cnt + 2'h1;
    next_cyc_clk = (next_cyc_cnt < 2'(porm_pkg::CYC_HALF));
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      // Count zero sits in the high half, so the first high phase is full length.
      cyc_cnt <= 2'h0;
      cyc_clk <= 1'b1;
    end
    else
    begin
      cyc_cnt <= next_cyc_cnt;
      cyc_clk <= next_cyc_clk;
    end
  end

  // ********************************************************************
  // Remappable pin outputs
  // ********************************************************************
  assign remap_dir = {dir_c[porm_pkg::BIT_RC7], dir_c[porm_pkg::BIT_RC6],
                      dir_c[porm_pkg::BIT_RC5], dir_a[porm_pkg::BIT_RA5]};

  // Each pin picks its own source; null or unused codes give no drive.
  generate
    for (genvar g = 0; g < porm_pkg::NUM_REMAP; g++)
    begin : g_remap
      logic [porm_pkg::SEL_W-1:0] code;
      assign code = sel_flat[g*porm_pkg::SEL_W +: porm_pkg::SEL_W];
      assign remap_val[g] = route_fn(code, {PWM_UNIT2_CHANNELS, PWM_UNIT1_CHANNELS,
                                            LOW_POWER_WAKE_EVENT, SERIAL_DMA_SLAVE_SELECT,
                                            SPI_PORT2_CLOCK_OUT, SPI_PORT2_DATA_OUT,
                                            SERIAL2_SYNC_DATA, SERIAL2_TX_OR_CLOCK,
                                            COMPARATOR_TWO_OUT, COMPARATOR_ONE_OUT});
      assign remap_on[g] = code_valid(code) && !remap_dir[g];
    end
  endgenerate

  // ********************************************************************
  // Pin drivers
  // ********************************************************************
  assign s1_mode = porm_pkg::porm_s1mode_e'(SERIAL1_MODE);

  // Peripheral outputs win over latch data; direction 1 tristates the pin, except PA6 in cycle clock mode.
  always_comb
  begin
    PA_OUT = lat_a;
    PA_OE  = ~dir_a & porm_pkg::PORT_A_IMPL;
    PC_OUT = lat_c;
    PC_OE  = ~dir_c;
    if (remap_on[0])
    begin
      PA_OUT[porm_pkg::BIT_RA5] = remap_val[0];
    end
    if (CYCLE_CLOCK_MODE)
    begin
      PA_OUT[porm_pkg::BIT_RA6] = cyc_clk;
      PA_OE[porm_pkg::BIT_RA6]  = 1'b1;
    end
    if (SPI_PORT1_ENABLE && !dir_c[porm_pkg::BIT_RC5])
    begin
      PC_OUT[porm_pkg::BIT_RC5] = SPI_PORT1_DATA_OUT;
    end
    else if (remap_on[1])
    begin
      PC_OUT[porm_pkg::BIT_RC5] = remap_val[1];
    end
    if (s1_mode == porm_pkg::PORM_S1_ASYNC)
    begin
      PC_OUT[porm_pkg::BIT_RC6] = SERIAL1_ASYNC_TX;
    end
    else if (s1_mode == porm_pkg::PORM_S1_SYNC)
    begin
      PC_OUT[porm_pkg::BIT_RC6] = SERIAL1_SYNC_CLOCK;
    end
    else if (remap_on[2])
    begin
      PC_OUT[porm_pkg::BIT_RC6] = remap_val[2];
    end
    if (s1_mode == porm_pkg::PORM_S1_SYNC)
    begin
      PC_OUT[porm_pkg::BIT_RC7] = SERIAL1_SYNC_DATA;
    end
    else if (remap_on[3])
    begin
      PC_OUT[porm_pkg::BIT_RC7] = remap_val[3];
    end
  end

  // Analog selection blanks the digital input of the channel four pin.
  assign an4_digital_off = !ana_cfg[porm_pkg::ANALOG_PIN_SELECT_BIT_AN4];
  always_comb
  begin
    PA_DIGITAL_IN = PA_IN & porm_pkg::PORT_A_IMPL;
    PC_DIGITAL_IN = PC_IN;
    if (an4_digital_off)
    begin
      PA_DIGITAL_IN[porm_pkg::BIT_RA5] = 1'b0;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  property p_null_no_drive;
    @(posedge CLK) disable iff (RESET)
    (sel_flat[4:0] == porm_pkg::SEL_NULL) |-> !remap_on[0];
  endproperty
  a_null_no_drive: assert property (p_null_no_drive) else $error("null select drove pin");

  property p_cmp1_route;
    @(posedge CLK) disable iff (RESET)
    (sel_flat[4:0] == porm_pkg::FN_CMP1 && !dir_a[porm_pkg::BIT_RA5] && !an4_digital_off)
      |-> PA_OUT[porm_pkg::BIT_RA5] == COMPARATOR_ONE_OUT;
  endproperty
  a_cmp1_route: assert property (p_cmp1_route) else $error("comparator one not routed");

  property p_sel_write;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == porm_pkg::REG_REMAP_SEL_RP17) |=> sel_flat[14:10] == $past(WDATA[4:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write lost");

  property p_input_tristate;
    @(posedge CLK) disable iff (RESET)
    dir_c[porm_pkg::BIT_RC7] |-> !PC_OE[porm_pkg::BIT_RC7];
  endproperty
  a_input_tristate: assert property (p_input_tristate) else $error("input pin driven");

  property p_tx_priority;
    @(posedge CLK) disable iff (RESET)
    (s1_mode == porm_pkg::PORM_S1_ASYNC) |-> PC_OUT[porm_pkg::BIT_RC6] == SERIAL1_ASYNC_TX;
  endproperty
  a_tx_priority: assert property (p_tx_priority) else $error("tx lost priority");

  property p_sync_data;
    @(posedge CLK) disable iff (RESET)
    (s1_mode == porm_pkg::PORM_S1_SYNC) |-> PC_OUT[porm_pkg::BIT_RC7] == SERIAL1_SYNC_DATA;
  endproperty
  a_sync_data: assert property (p_sync_data) else $error("sync data lost priority");

  property p_cycle_clock;
    @(posedge CLK) disable iff (RESET)
    CYCLE_CLOCK_MODE && $rose(cyc_clk) |=> cyc_clk ##1 !cyc_clk[*2] ##1 cyc_clk;
  endproperty
  a_cycle_clock: assert property (p_cycle_clock) else $error("cycle clock not quarter rate");

  property p_read_latency;
    @(posedge CLK) disable iff (RESET)
    (RD && ADDR == porm_pkg::REG_PORT_C_LATCH) |=> RDATA == $past(lat_c);
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data wrong");

  c_remap_pwm: cover property (@(posedge CLK) remap_on[1] && sel_flat[9:5] == porm_pkg::FN_P2D);
  c_sync_mode: cover property (@(posedge CLK) s1_mode == porm_pkg::PORM_S1_SYNC);
  c_analog_off: cover property (@(posedge CLK) !an4_digital_off);

endmodule

// ===== inc/porm_pkg.sv
// Package of constants for the remappable pin output multiplexer.
package porm_pkg;

  // ********************************************************************
  // Register bus and register indices
  // ********************************************************************
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_PORT_A_PINS      = 4'h0;
  localparam logic [3:0] REG_PORT_A_LATCH     = 4'h1;
  localparam logic [3:0] REG_PORT_A_DIRECTION = 4'h2;
  localparam logic [3:0] REG_ANALOG_CONFIG_0  = 4'h3;
  localparam logic [3:0] REG_PORT_C_PINS      = 4'h4;
  localparam logic [3:0] REG_PORT_C_LATCH     = 4'h5;
  localparam logic [3:0] REG_PORT_C_DIRECTION = 4'h6;
  localparam logic [3:0] REG_REMAP_SEL_RP2    = 4'h7;
  localparam logic [3:0] REG_REMAP_SEL_RP16   = 4'h8;
  localparam logic [3:0] REG_REMAP_SEL_RP17   = 4'h9;
  localparam logic [3:0] REG_REMAP_SEL_RP18   = 4'hA;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [7:0] RST_LATCH     = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_ANALOG    = 8'h00;
  localparam logic [4:0] SEL_NULL      = 5'h00;

  // ********************************************************************
  // Pin positions and field layout
  // ********************************************************************
  localparam int unsigned SEL_W        = 5;
  localparam int unsigned NUM_REMAP    = 4;
  localparam int unsigned BIT_RA5      = 5;
  localparam int unsigned BIT_RA6      = 6;
  localparam int unsigned BIT_RC5      = 5;
  localparam int unsigned BIT_RC6      = 6;
  localparam int unsigned BIT_RC7      = 7;
  localparam int unsigned ANALOG_PIN_SELECT_BIT_AN4     = 4;
  localparam logic [7:0]  PORT_A_IMPL  = 8'hEF;

  // ********************************************************************
  // Output function numbers
  // ********************************************************************
  localparam logic [4:0] FN_CMP1   = 5'h01;
  localparam logic [4:0] FN_CMP2   = 5'h02;
  localparam logic [4:0] FN_S2TXCK = 5'h05;
  localparam logic [4:0] FN_S2DT   = 5'h06;
  localparam logic [4:0] FN_SPI2DO = 5'h09;
  localparam logic [4:0] FN_SPI2CK = 5'h0A;
  localparam logic [4:0] FN_SERIAL_DMA_SLAVE_SELECT  = 5'h0C;
  localparam logic [4:0] FN_ULPW   = 5'h0D;
  localparam logic [4:0] FN_P1A    = 5'h0E;
  localparam logic [4:0] FN_P1D    = 5'h11;
  localparam logic [4:0] FN_P2A    = 5'h12;
  localparam logic [4:0] FN_P2D    = 5'h15;

  // ********************************************************************
  // Cycle clock divider
  // ********************************************************************
  localparam int unsigned CYC_DIV  = 4;
  localparam int unsigned CYC_HALF = CYC_DIV / 2;

  // Serial unit one modes.
  typedef enum logic [1:0]
  {
    PORM_S1_OFF   = 2'b00,
    PORM_S1_ASYNC = 2'b01,
    PORM_S1_SYNC  = 2'b10
  } porm_s1mode_e;

endpackage

// ===== rtl/porm_sel_reg.sv
// Per-pin remap select registers with registered read port.
`timescale 1ns/1ps
module porm_sel_reg
(
  // Clock and reset
  input  wire logic                                      clk,
  input  wire logic                                      reset,
  // Write port
  input  wire logic                                      wr_en,
  input  wire logic [1:0]                                wr_idx,
  input  wire logic [porm_pkg::SEL_W-1:0]                wr_data,
  // Read port
  input  wire logic [1:0]                                rd_idx,
  output logic      [porm_pkg::SEL_W-1:0]                rd_data,
  // All selects in parallel
  output logic      [porm_pkg::NUM_REMAP*porm_pkg::SEL_W-1:0] sel_flat
);

  logic [porm_pkg::SEL_W-1:0] sel      [porm_pkg::NUM_REMAP];
  logic [porm_pkg::SEL_W-1:0] next_sel [porm_pkg::NUM_REMAP];
  logic [porm_pkg::SEL_W-1:0] next_rd;

  // Next values: a write replaces one field, a read copies one field.
  always_comb
  begin
    for (int i = 0; i < porm_pkg::NUM_REMAP; i++)
    begin
      next_sel[i] = sel[i];
    end
    if (wr_en)
    begin
      next_sel[wr_idx] = wr_data;
    end
    next_rd = sel[rd_idx];
  end

  // Every field clears to the null code, so no pin is driven by a remappable peripheral.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < porm_pkg::NUM_REMAP; i++)
      begin
        sel[i] <= porm_pkg::SEL_NULL;
      end
      rd_data <= porm_pkg::SEL_NULL;
    end
    else
    begin
      for (int i = 0; i < porm_pkg::NUM_REMAP; i++)
      begin
        sel[i] <= next_sel[i];
      end
      rd_data <= next_rd;
    end
  end

  // Flatten for the pin multiplexers.
  generate
    for (genvar g = 0; g < porm_pkg::NUM_REMAP; g++)
    begin : g_flat
      assign sel_flat[g*porm_pkg::SEL_W +: porm_pkg::SEL_W] = sel[g];
    end
  endgenerate

endmodule

// ===== sim/porm_pins.sv
// Model of the outside circuitry that settles the level on each port pin.
`timescale 1ns/1ps
module porm_pins
(
  // Pins from the device
  input  wire logic [7:0] out,
  input  wire logic [7:0] oe,
  // Level put on released pins from outside
  input  wire logic [7:0] ext,
  // Settled pin level back to the device
  output logic      [7:0] level
);
  // A driven pin shows the device value; a released one shows the outside drive.
  // The outside drive is set by the bench, so a released pin never holds a stale value.
  assign level = (oe & out) | (~oe & ext);
endmodule

// ===== sim/porm_tb.sv
// Self-checking bench for the remappable pin output multiplexer.
`timescale 1ns/1ps
module testbench;
  // ********************************************************************
  // Signals
  // ********************************************************************
  logic       clk;
  logic       reset;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] pa_out, pa_oe, pa_in, pa_ext, pa_din;
  logic [7:0] pc_out, pc_oe, pc_in, pc_ext, pc_din;
  logic [15:0] src;
  logic [1:0] s1_mode;
  logic       s1_tx, s1_ck, s1_dt, spi1_en, spi1_do, ccm;
  int         n_fail;
  int         check_count;
  int         i, ones;
  // Implemented output function numbers, in the order of the bits of src.
  localparam logic [4:0] CODES [16] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h09, 5'h0A, 5'h0C,
    5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};

  // ********************************************************************
  // Design and pin model
  // ********************************************************************
  porm_top dut
  (
    .CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe),
    .PC_IN(pc_in), .PC_OUT(pc_out), .PC_OE(pc_oe),
    .COMPARATOR_ONE_OUT(src[0]), .COMPARATOR_TWO_OUT(src[1]),
    .SERIAL2_TX_OR_CLOCK(src[2]), .SERIAL2_SYNC_DATA(src[3]),
    .SPI_PORT2_DATA_OUT(src[4]), .SPI_PORT2_CLOCK_OUT(src[5]),
    .SERIAL_DMA_SLAVE_SELECT(src[6]), .LOW_POWER_WAKE_EVENT(src[7]),
    .PWM_UNIT1_CHANNELS(src[11:8]), .PWM_UNIT2_CHANNELS(src[15:12]),
    .SERIAL1_MODE(s1_mode), .SERIAL1_ASYNC_TX(s1_tx), .SERIAL1_SYNC_CLOCK(s1_ck),
    .SERIAL1_SYNC_DATA(s1_dt), .SPI_PORT1_ENABLE(spi1_en), .SPI_PORT1_DATA_OUT(spi1_do),
    .CYCLE_CLOCK_MODE(ccm), .PA_DIGITAL_IN(pa_din), .PC_DIGITAL_IN(pc_din)
  );
  porm_pins pins_a (.out(pa_out), .oe(pa_oe), .ext(pa_ext), .level(pa_in));
  porm_pins pins_c (.out(pc_out), .oe(pc_oe), .ext(pc_ext), .level(pc_in));

  // ********************************************************************
  // Tasks
  // ********************************************************************
  // Verdict and end of run, shared by the main sequence and the watchdog.
  task automatic results();
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Compare one result; an unknown bit matches only an unknown bit.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; data stand only in the next cycle.
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Apply peripheral levels after an edge and compare one port C output bit.
  task automatic pin_chk(input logic [15:0] s, input int b, input logic exp);
    @(posedge clk);
    src <= s;
    #1 chk({7'h00, pc_out[b]}, {7'h00, exp});
  endtask

  // ********************************************************************
  // Clock, watchdog and main sequence
  // ********************************************************************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // A hang is cut short well inside the cycle budget.
  initial
  begin
    #400000;
    n_fail++;
    results();
  end

  initial
  begin
    {addr, wdata, wr, rd, src, s1_mode, s1_tx, s1_ck, s1_dt} = '0;
    {spi1_en, spi1_do, ccm, n_fail, check_count} = '0;
    pa_ext = 8'hFF;
    pc_ext = 8'hA5;
    reset = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd_chk(porm_pkg::REG_PORT_A_DIRECTION, 8'hEF);
    rd_chk(porm_pkg::REG_PORT_A_PINS, 8'hCF);
    rd_chk(porm_pkg::REG_ANALOG_CONFIG_0, 8'h00);
    rd_chk(porm_pkg::REG_PORT_C_DIRECTION, 8'hFF);
    rd_chk(porm_pkg::REG_REMAP_SEL_RP2, 8'h00);
    rd_chk(porm_pkg::REG_REMAP_SEL_RP16, 8'h00);
    rd_chk(porm_pkg::REG_REMAP_SEL_RP17, 8'h00);
    rd_chk(porm_pkg::REG_REMAP_SEL_RP18, 8'h00);
    rd_chk(4'hB, 8'h00);
    rd_chk(porm_pkg::REG_PORT_C_PINS, 8'hA5);
    wr_reg(porm_pkg::REG_PORT_C_PINS, 8'h3C);
    rd_chk(porm_pkg::REG_PORT_C_LATCH, 8'h3C);
    wr_reg(porm_pkg::REG_PORT_C_LATCH, 8'h00);
    wr_reg(porm_pkg::REG_PORT_C_DIRECTION, 8'h1F);
    // Every implemented code routes exactly its own source to PC5.
    for (i = 0; i < 16; i++)
    begin
      wr_reg(porm_pkg::REG_REMAP_SEL_RP16, {3'h0, CODES[i]});
      rd_chk(porm_pkg::REG_REMAP_SEL_RP16, {3'h0, CODES[i]});
      pin_chk(16'h0001 << i, 5, 1'b1);
      pin_chk(~(16'h0001 << i), 5, 1'b0);
    end
    wr_reg(porm_pkg::REG_REMAP_SEL_RP16, 8'hE0);
    pin_chk(16'hFFFF, 5, 1'b0);
    wr_reg(porm_pkg::REG_REMAP_SEL_RP16, 8'h03);
    pin_chk(16'hFFFF, 5, 1'b0);
    // Fixed peripherals beat both the latch and the remap selection.
    wr_reg(porm_pkg::REG_REMAP_SEL_RP16, {3'h0, porm_pkg::FN_CMP1});
    wr_reg(porm_pkg::REG_REMAP_SEL_RP17, {3'h0, porm_pkg::FN_CMP1});
    wr_reg(porm_pkg::REG_REMAP_SEL_RP18, {3'h0, porm_pkg::FN_CMP1});
    rd_chk(porm_pkg::REG_REMAP_SEL_RP17, {3'h0, porm_pkg::FN_CMP1});
    spi1_en <= 1'b1;
    pin_chk(16'hFFFF, 5, 1'b0);
    @(posedge clk);
    s1_mode <= porm_pkg::PORM_S1_ASYNC;
    pin_chk(16'hFFFF, 6, 1'b0);
    @(posedge clk);
    s1_mode <= porm_pkg::PORM_S1_SYNC;
    pin_chk(16'hFFFF, 6, 1'b0);
    pin_chk(16'hFFFF, 7, 1'b0);
    @(posedge clk);
    s1_ck <= 1'b1;
    pin_chk(16'hFFFF, 6, 1'b1);
    // With direction set to input the clock and data pins are released.
    wr_reg(porm_pkg::REG_PORT_C_DIRECTION, 8'hDF);
    #1 chk(pc_oe, 8'h20);
    // Latch drives the analog pin; digital input stays off until digital.
    wr_reg(porm_pkg::REG_PORT_A_LATCH, 8'h20);
    wr_reg(porm_pkg::REG_PORT_A_DIRECTION, 8'hCF);
    #1 chk({pa_out[5], pa_oe[5]}, 8'h03);
    wr_reg(porm_pkg::REG_PORT_A_DIRECTION, 8'hEF);
    #1 chk({7'h00, pa_din[5]}, 8'h00);
    wr_reg(porm_pkg::REG_ANALOG_CONFIG_0, 8'h10);
    #1 chk({7'h00, pa_din[5]}, 8'h01);
    // The port A remappable pin follows its select over a latch of one.
    wr_reg(porm_pkg::REG_REMAP_SEL_RP2, {3'h0, porm_pkg::FN_CMP1});
    rd_chk(porm_pkg::REG_REMAP_SEL_RP2, {3'h0, porm_pkg::FN_CMP1});
    wr_reg(porm_pkg::REG_PORT_A_DIRECTION, 8'hCF);
    src <= 16'hFFFE;
    #1 chk({7'h00, pa_out[5]}, 8'h00);
    @(posedge clk);
    src <= 16'h0001;
    #1 chk({7'h00, pa_out[5]}, 8'h01);
    // With serial one and the data port idle, the remap reaches PC5 to PC7.
    @(posedge clk);
    s1_mode <= porm_pkg::PORM_S1_OFF;
    spi1_en <= 1'b0;
    wr_reg(porm_pkg::REG_PORT_C_DIRECTION, 8'h1F);
    pin_chk(16'h0001, 5, 1'b1);
    pin_chk(16'h0001, 6, 1'b1);
    pin_chk(16'h0001, 7, 1'b1);
    wr_reg(porm_pkg::REG_PORT_C_DIRECTION, 8'hFF);
    pin_chk(16'h0001, 5, 1'b0);
    // Cycle clock drives PA6 whatever the direction, high half of each period of four.
    ccm <= 1'b1;
    ones = 0;
    for (i = 0; i < porm_pkg::CYC_DIV; i++)
    begin
      @(posedge clk);
      #1 ones += pa_out[6];
      chk({7'h00, pa_oe[6]}, 8'h01);
    end
    chk(8'(ones), 8'(porm_pkg::CYC_HALF));
    results();
  end
endmodule
